// ### dv/efm_field_model.sv
// field side: switches, relays, drive and speed counter
module efm_field_model
  import efm_pkg::*;
(
  input wire logic sys_clk,
  output efm_field_t fld
);
  timeunit 1ns;
  timeprecision 1ns;
  int lag;
  int cnt;

  // idle car: at a floor, doors closed, drive healthy
  initial begin
    fld = '0;
    fld.doorContactRelay = 1'b1;
    fld.doorClosedLimit = 1'b1;
    fld.doorZone = 1'b1;
    fld.driveReady = 1'b1;
    fld.driveOn = 1'b1;
    fld.partnerOk = 1'b1;
    fld.ropeCheckOk = 1'b1;
    fld.counterFitted = 1'b1;
    fld.runUp = 1'b1;
    fld.carMovingUp = 1'b1;
    lag = 2;
    cnt = 0;
  end

  // brake switch and run contacts follow the run command after lag
  always @(posedge sys_clk) begin
    if (fld.brakeSw != fld.runCmd) begin
      cnt <= cnt + 1;
      if (cnt >= lag) begin
        fld.brakeSw <= fld.runCmd;
        fld.brakeContactOne <= fld.runCmd;
        fld.brakeContactTwo <= fld.runCmd;
        fld.runContactZ <= fld.runCmd;
        fld.runContactX <= fld.runCmd;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule // efm_field_model

// ### dv/elevator_fault_monitor_tb.sv
module elevator_fault_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import efm_pkg::*;
  localparam int SEC = 20;
  logic sysClk = 1'b0;
  logic resetN = 1'b0;
  logic ce = 1'b1;
  efm_field_t fld;
  logic [7:0] busAddr = 8'h00;
  logic [15:0] busWdata = 16'h0000;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [15:0] busRdata;
  efm_act_t act;
  int failCount = 0;
  int nTests = 0;
  int cyc = 0;

  efm_field_model efm_field_model_inst (.sys_clk(sysClk), .fld(fld));
  efm_monitor #(.SEC_CYCLES(SEC)) efm_monitor_inst (
    .sys_clk(sysClk), .reset_n(resetN), .ce(ce), .fld(fld),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata), .act(act));

  // clock and cycle count since reset release
  initial begin
    forever #12.5 sysClk = ~sysClk;
  end
  always @(posedge sysClk) if (resetN) cyc <= cyc + 1;

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sysClk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge sysClk);
    busWr <= 1'b0;
  endtask

  task automatic chkReg(input string what, input logic [7:0] a,
                        input logic [15:0] exp);
    @(posedge sysClk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge sysClk);
    busRd <= 1'b0;
    #1 check(what, exp, busRdata);
  endtask

  // newest log entry code, stamp byte ignored
  task automatic chkCode(input string what, input logic [7:0] code);
    @(posedge sysClk);
    busRd <= 1'b1;
    busAddr <= EFM_A_LOG;
    @(posedge sysClk);
    busRd <= 1'b0;
    #1 check(what, {8'h00, code}, {8'h00, busRdata[15:8]});
  endtask

  // bounded wait for one action bit, returns cycles taken
  task automatic waitAct(input int idx, input int maxCyc, output int took);
    took = 0;
    do begin
      @(posedge sysClk);
      #1 took++;
    end while (act[idx] !== 1'b1 && took < maxCyc);
    check("action bit seen", 16'h0001, {15'h0, act[idx]});
  endtask

  task automatic cycleInspection();
    @(posedge sysClk) efm_field_model_inst.fld.inspection <= 1'b1;
    repeat (3) @(posedge sysClk);
    efm_field_model_inst.fld.inspection <= 1'b0;
    repeat (3) @(posedge sysClk);
  endtask

  task automatic stopAtFloor();
    @(posedge sysClk) efm_field_model_inst.fld.doorZone <= 1'b1;
    @(posedge sysClk) efm_field_model_inst.fld.runCmd <= 1'b0;
    repeat (5) @(posedge sysClk);
  endtask

  task automatic t_reset();
    #1 check("act after reset", 16'h0000, {10'h0, act});
    chkReg("run shutdown default", EFM_A_RUNSHDN, 16'h0019);
    chkReg("drive limit default", EFM_A_DRVLIM, 16'h0004);
    chkReg("stamp after reset", EFM_A_STAMP, 16'h0000);
    chkReg("log empty", EFM_A_LOG, 16'h0000);
    wrReg(8'h3f, 16'h00aa);
    chkReg("unmapped read", 8'h3f, 16'h0000);
    wrReg(EFM_A_RUNSHDN, 16'h001a);
    chkReg("run shutdown written", EFM_A_RUNSHDN, 16'h001a);
    wrReg(EFM_A_RUNSHDN, 16'h0019);
  endtask

  task automatic t_level();
    @(posedge sysClk);
    efm_field_model_inst.fld.levelUp <= 1'b1;
    efm_field_model_inst.fld.levelDown <= 1'b1;
    repeat (40) @(posedge sysClk);
    chkCode("both level switches", 8'h12);
    chkReg("held fault logged once", EFM_A_LOG + 8'h01, 16'h0000);
    @(posedge sysClk);
    efm_field_model_inst.fld.levelUp <= 1'b0;
    efm_field_model_inst.fld.levelDown <= 1'b0;
  endtask

  // up, down, up while stopped blocks relevel until a floor pass
  task automatic t_relevel();
    @(posedge sysClk) efm_field_model_inst.fld.levelUp <= 1'b1;
    repeat (3) @(posedge sysClk);
    efm_field_model_inst.fld.levelUp <= 1'b0;
    efm_field_model_inst.fld.levelDown <= 1'b1;
    repeat (3) @(posedge sysClk);
    efm_field_model_inst.fld.levelDown <= 1'b0;
    efm_field_model_inst.fld.levelUp <= 1'b1;
    repeat (3) @(posedge sysClk);
    efm_field_model_inst.fld.levelUp <= 1'b0;
    #1 check("relevel blocked", 16'h0001, {15'h0, act.relevelBlock});
    chkCode("leveling fault code", 8'h04);
    @(posedge sysClk) efm_field_model_inst.fld.floorPass <= 1'b1;
    @(posedge sysClk) efm_field_model_inst.fld.floorPass <= 1'b0;
    @(posedge sysClk);
    #1 check("relevel freed", 16'h0000, {15'h0, act.relevelBlock});
  endtask

  // lost tachometer flags overspeed as a level
  task automatic t_overspeed();
    @(posedge sysClk) efm_field_model_inst.fld.tachLost <= 1'b1;
    repeat (3) @(posedge sysClk);
    #1 check("overspeed on", 16'h0001, {15'h0, act.overspeed});
    chkCode("overspeed code", 8'h0b);
    @(posedge sysClk) efm_field_model_inst.fld.tachLost <= 1'b0;
    repeat (2) @(posedge sysClk);
    #1 check("overspeed off", 16'h0000, {15'h0, act.overspeed});
  endtask

  task automatic t_runShutdown();
    int took;
    @(posedge sysClk);
    efm_field_model_inst.fld.doorZone <= 1'b0;
    efm_field_model_inst.fld.runCmd <= 1'b1;
    waitAct(5, 27 * SEC, took);
    check("shutdown not early", 16'h0001, {15'h0, took >= 25 * SEC});
    check("return bottom", 16'h0001, {15'h0, act.returnBottom});
    chkCode("run shutdown code", 8'h01);
    stopAtFloor();
    cycleInspection();
    #1 check("stop cleared", 16'h0000, {15'h0, act.stopCar});
  endtask

  task automatic t_brake();
    int took;
    efm_field_model_inst.lag = 1000000;
    @(posedge sysClk);
    efm_field_model_inst.fld.doorZone <= 1'b0;
    efm_field_model_inst.fld.runCmd <= 1'b1;
    waitAct(3, 5 * SEC, took);
    check("brake not early", 16'h0001, {15'h0, took >= 3 * SEC});
    chkCode("brake fault code", 8'h02);
    stopAtFloor();
    efm_field_model_inst.lag = 2;
    cycleInspection();
    #1 check("shutdown cleared", 16'h0000, {15'h0, act.shutdown});
  endtask

  task automatic t_runaway();
    int took;
    @(posedge sysClk) efm_field_model_inst.fld.speedFpm <= 12'h032;
    repeat (10) @(posedge sysClk);
    #1 check("no trip at 50", 16'h0000, {15'h0, act.ropeBrakeSet});
    @(posedge sysClk) efm_field_model_inst.fld.speedFpm <= 12'h033;
    waitAct(2, 5, took);
    chkCode("runaway code", 8'h17);
    @(posedge sysClk) efm_field_model_inst.fld.speedFpm <= 12'h000;
    @(posedge sysClk) efm_field_model_inst.fld.shutdownDefeat <= 1'b1;
    repeat (4) @(posedge sysClk);
    #1 check("rope brake cleared", 16'h0000,
             {15'h0, act.ropeBrakeSet});
    @(posedge sysClk);
    efm_field_model_inst.fld.shutdownDefeat <= 1'b0;
  endtask

  task automatic t_doorContact();
    @(posedge sysClk);
    efm_field_model_inst.fld.doorZone <= 1'b0;
    efm_field_model_inst.fld.runCmd <= 1'b1;
    repeat (10) @(posedge sysClk);
    efm_field_model_inst.fld.doorContactRelay <= 1'b0;
    repeat (5) @(posedge sysClk);
    chkCode("door contact code", 8'h08);
    @(posedge sysClk);
    efm_field_model_inst.fld.doorContactRelay <= 1'b1;
    stopAtFloor();
  endtask

  task automatic t_coil();
    wrReg(EFM_A_RUNSHDN, 16'h0030);
    wrReg(EFM_A_CTRL, 16'h0001);
    repeat (3) @(posedge sysClk);
    chkReg("coil self-clears", EFM_A_CTRL, 16'h0000);
    chkReg("default restored", EFM_A_RUNSHDN, 16'h0019);
  endtask

  task automatic t_stamp();
    wait (cyc >= 358 * SEC);
    chkReg("stamp before six minutes", EFM_A_STAMP, 16'h0000);
    wait (cyc >= 362 * SEC);
    chkReg("stamp after six minutes", EFM_A_STAMP, 16'h0001);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog sized for the stamp wait plus margin
  initial begin
    repeat (400 * SEC + 2000) @(posedge sysClk);
    failCount++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge sysClk);
    resetN <= 1'b1;
    t_reset();
    t_level();
    t_relevel();
    t_runShutdown();
    t_brake();
    t_runaway();
    t_overspeed();
    t_doorContact();
    t_coil();
    t_stamp();
    summarize();
  end
endmodule // elevator_fault_monitor_tb

// ### logic/efm_monitor.sv
// Notes on behaviour
// - push code 00 marker at daily rollover
// - run without floor: log 01, stop, bottom
// - run shutdown time defaults to 25 seconds
// - run inputs stuck 3 s: log 02, shutdown
// - drive resets over limit log 03
// - leveling long or oscillating: 04, block relevel
// - door open limit not reached: log 06
// - failed commanded close logs 07, holds excluded
// - door contact drop while running logs 08
// - stop outside door zone logs 09
// - idle at floor too long logs 0A
// - speed counter overspeed cases flag fault 0B
// - rope brake cleared by defeat rising edge
// - leaving door zone doors open logs 0E
// - over 50 FPM without run: 17, rope brake
// - duplex partner silent 5 s logs 10
// - both level switches on logs 12
// - fast run missing floor: 1E, 20 shutdown
// - rope brake check failure at start logs 1A
// - drive ready 0F, drive on 11, zone 1B
// - default coil restores settings then self-clears
// - 8-bit stamp every six minutes, EF wraps
// - 50 entry log, newest first
module efm_monitor
  import efm_pkg::*;
#(
  parameter int SEC_CYCLES = EFM_SEC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire efm_field_t fld,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [15:0] busRdata,
  output efm_act_t act
);

  efm_state_t s;
  efm_state_t next_s;
  logic [EFM_NF-1:0] c;
  logic [EFM_NF-1:0] raise;
  logic [EFM_NF-1:0] pick;
  logic [7:0] code;
  logic [7:0] logIdx;
  logic runStart;
  logic runEnd;
  logic insToggle;
  logic defeatRise;
  logic openWait;
  logic closeWait;
  logic mis;

  // second timer step, saturating, cleared when idle
  function automatic logic [7:0] tmr8(input logic run, input logic [7:0] t,
                                      input logic tick);
    logic [7:0] r;
    r = t;
    if (!run) begin
      r = '0;
    end else if (tick && t != EFM_T8_MAX) begin
      r = t + 8'h01;
    end
    return r;
  endfunction

  // all next-state logic
  always_comb begin
    next_s = s;
    c = '0;
    code = '0;
    runStart = fld.runCmd & ~s.prev.runCmd;
    runEnd = s.prev.runCmd & ~fld.runCmd;
    insToggle = fld.inspection ^ s.prev.inspection;
    defeatRise = fld.shutdownDefeat & ~s.prev.shutdownDefeat;
    openWait = fld.doorOpenCmd & ~fld.doorOpenLimit;
    closeWait = fld.doorCloseCmd & ~fld.doorHeldOpen & ~fld.doorClosedLimit;
    mis = {fld.brakeSw, fld.brakeContactOne, fld.brakeContactTwo,
           fld.runContactZ, fld.runContactX} !=
          {EFM_RUN_INPUTS{fld.runCmd}};
    logIdx = busAddr - EFM_A_LOG;

    // one second tick
    next_s.secTick = 1'b0;
    if (s.pre == EFM_PRE_W'(SEC_CYCLES - 1)) begin
      next_s.pre = '0;
      next_s.secTick = 1'b1;
    end else begin
      next_s.pre = s.pre + 1'b1;
    end

    // time stamp, wraps once a day
    next_s.stampRoll = 1'b0;
    if (s.secTick) begin
      if (s.stampSec == EFM_STAMP_SEC - 9'h001) begin
        next_s.stampSec = '0;
        if (s.stamp == EFM_STAMP_LAST) begin
          next_s.stamp = '0;
          next_s.stampRoll = 1'b1;
        end else begin
          next_s.stamp = s.stamp + 8'h01;
        end
      end else begin
        next_s.stampSec = s.stampSec + 9'h001;
      end
    end

    // condition timers
    next_s.runTmr = tmr8(fld.runCmd & ~fld.floorPass, s.runTmr, s.secTick);
    next_s.brkTmr = tmr8(mis, s.brkTmr, s.secTick);
    next_s.levTmr = tmr8(fld.levelUp | fld.levelDown, s.levTmr, s.secTick);
    next_s.doorTmr = tmr8(openWait | closeWait, s.doorTmr, s.secTick);
    next_s.stuckTmr = tmr8(~fld.runCmd & fld.doorZone, s.stuckTmr,
                           s.secTick);
    next_s.dupTmr = tmr8(~fld.partnerOk, s.dupTmr, s.secTick);
    next_s.dzTmr = tmr8(fld.runCmd & fld.doorZone, s.dzTmr, s.secTick);

    // leveling reversal tracking, restarted by each run
    if (fld.runCmd) begin
      next_s.levSeen = 1'b0;
      next_s.levFlips = '0;
    end else if (fld.levelUp ^ fld.levelDown) begin
      next_s.levSeen = 1'b1;
      next_s.levLastUp = fld.levelUp;
      if (s.levSeen && s.levLastUp != fld.levelUp &&
          s.levFlips != EFM_LEV_FLIPS) begin
        next_s.levFlips = s.levFlips + 2'h1;
      end
    end

    // fast speed run bookkeeping
    if (runStart) begin
      next_s.fsRun = 1'b0;
      next_s.floorSeen = 1'b0;
    end
    if (fld.runCmd & fld.fastSpeedRelay) begin
      next_s.fsRun = 1'b1;
    end
    if (fld.floorPass) begin
      next_s.floorSeen = 1'b1;
    end

    // fault conditions
    c[F_ROLL] = s.stampRoll;
    c[F_RUN] = fld.runCmd && s.runTmr > s.cfg.runShdnSec;
    c[F_BRK] = s.brkTmr > EFM_BRK_SEC;
    c[F_DRV] = s.drvResets > s.cfg.drvResetLimit;
    c[F_LEV] = (s.levTmr > EFM_LEV_SEC) ||
               (s.levFlips == EFM_LEV_FLIPS);
    c[F_DOPEN] = openWait && s.doorTmr > s.cfg.doorSec;
    c[F_DCLOSE] = closeWait && s.doorTmr > s.cfg.doorSec;
    c[F_DCONT] = s.prev.runCmd & fld.runCmd & s.prev.doorContactRelay &
                 ~fld.doorContactRelay;
    c[F_DZONE] = runEnd & ~fld.doorZone;
    c[F_STUCK] = s.stuckTmr > s.cfg.stuckSec;
    c[F_OVSP] = fld.counterFitted && (fld.tachLost ||
      (16'(fld.speedFpm) * EFM_PCT_DEN > 16'(s.cfg.contractFpm) *
       EFM_PCT_NUM) ||
      (fld.inspection && fld.speedFpm > EFM_INSP_FPM) ||
      (!fld.doorContactRelay && fld.speedFpm > EFM_SLOW_FPM) ||
      (fld.runCmd && fld.speedFpm != '0 &&
       fld.carMovingUp != fld.runUp));
    c[F_ROPE] = s.prev.doorZone & ~fld.doorZone &
                ~fld.doorContactRelay;
    c[F_DRDY] = s.prev.driveReady & ~fld.driveReady;
    c[F_DUP] = s.dupTmr > EFM_DUP_SEC;
    c[F_DON] = s.prev.runCmd & fld.runCmd & s.prev.driveOn &
               ~fld.driveOn;
    c[F_LVB] = fld.levelUp & fld.levelDown;
    c[F_RUNAWAY] = !fld.runCmd && fld.speedFpm > EFM_SLOW_FPM;
    c[F_RBCHK] = runStart & ~fld.ropeCheckOk;
    c[F_DZSTK] = s.dzTmr > EFM_DZ_STUCK_SEC;
    c[F_FS] = runEnd & s.fsRun & ~s.floorSeen;

    // only entry into a fault state raises its code
    raise = c & ~s.condPrev;
    next_s.condPrev = c;

    // lowest pending slot goes to the log first
    pick = s.pend & (~s.pend + EFM_NF'(1));
    for (int i = 0; i < EFM_NF; i++) begin
      if (pick[i]) begin
        code = EFM_CODE[i];
      end
    end
    next_s.pend = (s.pend & ~pick) | raise;
    if (|s.pend) begin
      next_s.log = {s.log[EFM_LOG_N-2:0], code, s.stamp};
    end

    // drive reset counting, cleared after a clean run period
    if (fld.driveFault || (fld.driveResetReq && !s.prev.driveResetReq)) begin
      next_s.cleanTmr = '0;
    end else if (fld.driveOn && s.secTick) begin
      if (s.cleanTmr >= EFM_CLEAN_SEC - 10'h001) begin
        next_s.cleanTmr = '0;
        next_s.drvResets = '0;
      end else begin
        next_s.cleanTmr = s.cleanTmr + 10'h001;
      end
    end
    if (fld.driveResetReq && !s.prev.driveResetReq &&
        s.drvResets != EFM_T8_MAX) begin
      next_s.drvResets = next_s.drvResets + 8'h01;
    end

    // fast speed failure count, cleared by an inspection toggle
    next_s.fsFails = insToggle ? 8'h00 : s.fsFails;
    if (raise[F_FS] && s.fsFails != EFM_T8_MAX) begin
      next_s.fsFails = next_s.fsFails + 8'h01;
    end

    // latched actions except overspeed, which follows its condition; a new trip wins over its clear
    next_s.act.stopCar = raise[F_RUN] | (s.act.stopCar & ~insToggle);
    next_s.act.returnBottom = raise[F_RUN] |
                              (s.act.returnBottom & ~insToggle);
    next_s.act.shutdown = raise[F_BRK] | (next_s.fsFails >= EFM_FS_LIMIT) |
                          (s.act.shutdown & ~insToggle);
    next_s.act.ropeBrakeSet = raise[F_ROPE] | raise[F_RUNAWAY] |
                              (s.act.ropeBrakeSet & ~defeatRise);
    next_s.act.relevelBlock = raise[F_LEV] |
                              (s.act.relevelBlock & ~fld.floorPass);
    next_s.act.overspeed = c[F_OVSP];
    next_s.prev = fld;

    // default coil restores settings and drops itself
    if (s.coil) begin
      next_s.cfg = EFM_CFG_DEF;
      next_s.coil = 1'b0;
    end

    // register writes
    if (busWr) begin
      case (busAddr)
        EFM_A_CTRL: next_s.coil = busWdata[EFM_CTRL_COIL_BIT];
        EFM_A_RUNSHDN: next_s.cfg.runShdnSec = busWdata[7:0];
        EFM_A_DOOR: next_s.cfg.doorSec = busWdata[7:0];
        EFM_A_STUCK: next_s.cfg.stuckSec = busWdata[7:0];
        EFM_A_DRVLIM: next_s.cfg.drvResetLimit = busWdata[7:0];
        EFM_A_CONTRACT: next_s.cfg.contractFpm = busWdata[11:0];
        default: ;
      endcase
    end

    // register reads, data valid in the next cycle only
    next_s.rdata = '0;
    if (busRd) begin
      case (busAddr)
        EFM_A_CTRL: next_s.rdata = {15'h0000, s.coil};
        EFM_A_RUNSHDN: next_s.rdata = {8'h00, s.cfg.runShdnSec};
        EFM_A_DOOR: next_s.rdata = {8'h00, s.cfg.doorSec};
        EFM_A_STUCK: next_s.rdata = {8'h00, s.cfg.stuckSec};
        EFM_A_DRVLIM: next_s.rdata = {8'h00, s.cfg.drvResetLimit};
        EFM_A_CONTRACT: next_s.rdata = {4'h0, s.cfg.contractFpm};
        EFM_A_STAMP: next_s.rdata = {8'h00, s.stamp};
        EFM_A_STATUS: next_s.rdata = {s.fsFails, 2'h0, s.act};
        default: begin
          if (busAddr >= EFM_A_LOG && logIdx < EFM_LOG_N8) begin
            next_s.rdata = s.log[logIdx[5:0]];
          end
        end
      endcase
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.cfg <= EFM_CFG_DEF;
      s.prev.shutdownDefeat <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign busRdata = s.rdata;
  assign act = s.act;

  // checks
  property p_stamp_wrap;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.secTick && s.stampSec == EFM_STAMP_SEC - 9'h001 &&
     s.stamp == EFM_STAMP_LAST) |=> (s.stamp == 8'h00 && s.stampRoll);
  endproperty
  a_stamp_wrap: assert property (p_stamp_wrap)
    else $error("stamp did not wrap to zero");

  property p_roll_log;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.stampRoll && !s.condPrev[F_ROLL]) |=> s.pend[F_ROLL];
  endproperty
  a_roll_log: assert property (p_roll_log)
    else $error("rollover marker not queued");

  property p_run_stop;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && raise[F_RUN]) |=>
      (s.act.stopCar && s.act.returnBottom && s.pend[F_RUN]);
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("run timeout did not stop car");

  property p_brake_shut;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.brkTmr > EFM_BRK_SEC && !s.condPrev[F_BRK]) |=>
      (s.act.shutdown && s.pend[F_BRK]);
  endproperty
  a_brake_shut: assert property (p_brake_shut)
    else $error("brake timer did not shut down");

  property p_push_order;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.pend != '0) |=> (s.log[1] == $past(s.log[0]));
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("log did not shift by one");

  property p_once;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.condPrev[F_LVB] && c[F_LVB] && !s.pend[F_LVB]) |=>
      !s.pend[F_LVB];
  endproperty
  a_once: assert property (p_once)
    else $error("held fault logged twice");

  property p_rope_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && defeatRise && !raise[F_ROPE] && !raise[F_RUNAWAY]) |=>
      !s.act.ropeBrakeSet;
  endproperty
  a_rope_clear: assert property (p_rope_clear)
    else $error("rope brake not cleared");

  property p_runaway;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && raise[F_RUNAWAY]) |=> (s.act.ropeBrakeSet && s.pend[F_RUNAWAY]);
  endproperty
  a_runaway: assert property (p_runaway)
    else $error("runaway did not set rope brake");

  property p_coil;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.coil && !busWr) |=> (!s.coil && s.cfg == EFM_CFG_DEF);
  endproperty
  a_coil: assert property (p_coil)
    else $error("default coil did not restore");

  property p_fs_shut;
    @(posedge sys_clk) disable iff (!reset_n)
    (s.fsFails >= EFM_FS_LIMIT) |-> s.act.shutdown;
  endproperty
  a_fs_shut: assert property (p_fs_shut)
    else $error("fast speed limit without shutdown");

  property p_relevel;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && raise[F_LEV]) |=> s.act.relevelBlock;
  endproperty
  a_relevel: assert property (p_relevel)
    else $error("leveling fault did not block");

  property p_ovsp_level;
    @(posedge sys_clk) disable iff (!reset_n)
    ce |=> (s.act.overspeed == $past(c[F_OVSP]));
  endproperty
  a_ovsp_level: assert property (p_ovsp_level)
    else $error("overspeed flag not following condition");

  property p_stuck;
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && s.stuckTmr > s.cfg.stuckSec && !s.condPrev[F_STUCK]) |=>
      s.pend[F_STUCK];
  endproperty
  a_stuck: assert property (p_stuck)
    else $error("car stuck fault not queued");

endmodule // efm_monitor

// ### pkg/efm_pkg.sv
package efm_pkg;

  // clock and time base
  localparam int EFM_CLK_PERIOD_NS = 25;
  localparam int EFM_SECOND_NS = 1_000_000_000;
  localparam int EFM_SEC_CYCLES = EFM_SECOND_NS / EFM_CLK_PERIOD_NS;
  localparam int EFM_PRE_W = 26;
  localparam int EFM_STAMP_MIN = 6;
  localparam logic [8:0] EFM_STAMP_SEC = 9'(EFM_STAMP_MIN * 60);
  localparam logic [7:0] EFM_STAMP_LAST = 8'hef;

  // fixed fault timings in seconds, then counts and limits
  localparam logic [7:0] EFM_BRK_SEC = 8'h03;
  localparam logic [7:0] EFM_LEV_SEC = 8'h0f;
  localparam logic [7:0] EFM_DUP_SEC = 8'h05;
  localparam logic [7:0] EFM_DZ_STUCK_SEC = 8'h0a;
  localparam logic [9:0] EFM_CLEAN_SEC = 10'h384;
  localparam logic [7:0] EFM_T8_MAX = 8'hff;
  localparam logic [7:0] EFM_FS_LIMIT = 8'h14;
  localparam logic [1:0] EFM_LEV_FLIPS = 2'h2;
  localparam int EFM_RUN_INPUTS = 5;

  // speed limits
  localparam logic [11:0] EFM_INSP_FPM = 12'h096;
  localparam logic [11:0] EFM_SLOW_FPM = 12'h032;
  localparam logic [15:0] EFM_PCT_NUM = 16'h000b;
  localparam logic [15:0] EFM_PCT_DEN = 16'h000a;

  // fault slots and their log codes
  localparam int EFM_NF = 20;
  localparam int F_ROLL = 0, F_RUN = 1, F_BRK = 2, F_DRV = 3, F_LEV = 4;
  localparam int F_DOPEN = 5, F_DCLOSE = 6, F_DCONT = 7, F_DZONE = 8;
  localparam int F_STUCK = 9, F_OVSP = 10, F_ROPE = 11, F_DRDY = 12;
  localparam int F_DUP = 13, F_DON = 14, F_LVB = 15, F_RUNAWAY = 16;
  localparam int F_RBCHK = 17, F_DZSTK = 18, F_FS = 19;
  localparam logic [7:0] EFM_CODE [EFM_NF] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
    8'h0b, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h17, 8'h1a, 8'h1b, 8'h1e};

  // register map, word addresses
  localparam logic [7:0] EFM_A_CTRL = 8'h00;
  localparam logic [7:0] EFM_A_RUNSHDN = 8'h01;
  localparam logic [7:0] EFM_A_DOOR = 8'h02;
  localparam logic [7:0] EFM_A_STUCK = 8'h03;
  localparam logic [7:0] EFM_A_DRVLIM = 8'h04;
  localparam logic [7:0] EFM_A_CONTRACT = 8'h05;
  localparam logic [7:0] EFM_A_STAMP = 8'h06;
  localparam logic [7:0] EFM_A_STATUS = 8'h07;
  localparam logic [7:0] EFM_A_LOG = 8'h40;
  localparam int EFM_LOG_N = 50;
  localparam logic [7:0] EFM_LOG_N8 = 8'h32;
  localparam int EFM_CTRL_COIL_BIT = 0;

  typedef struct packed {
    logic [7:0] runShdnSec;
    logic [7:0] doorSec;
    logic [7:0] stuckSec;
    logic [7:0] drvResetLimit;
    logic [11:0] contractFpm;
  } efm_cfg_t;

  localparam efm_cfg_t EFM_CFG_DEF = '{
    runShdnSec: 8'h19, doorSec: 8'h14, stuckSec: 8'h3c,
    drvResetLimit: 8'h04, contractFpm: 12'h15e};

  typedef struct packed {
    logic runCmd;
    logic runUp;
    logic floorPass;
    logic brakeSw;
    logic brakeContactOne;
    logic brakeContactTwo;
    logic runContactZ;
    logic runContactX;
    logic fastSpeedRelay;
    logic doorContactRelay;
    logic doorOpenCmd;
    logic doorOpenLimit;
    logic doorCloseCmd;
    logic doorHeldOpen;
    logic doorClosedLimit;
    logic doorZone;
    logic levelUp;
    logic levelDown;
    logic inspection;
    logic shutdownDefeat;
    logic partnerOk;
    logic driveResetReq;
    logic driveFault;
    logic driveReady;
    logic driveOn;
    logic ropeCheckOk;
    logic counterFitted;
    logic tachLost;
    logic carMovingUp;
    logic [11:0] speedFpm;
  } efm_field_t;

  typedef struct packed {
    logic stopCar;
    logic returnBottom;
    logic shutdown;
    logic ropeBrakeSet;
    logic relevelBlock;
    logic overspeed;
  } efm_act_t;

  typedef struct packed {
    efm_field_t prev;
    logic [EFM_PRE_W-1:0] pre;
    logic secTick;
    logic [8:0] stampSec;
    logic [7:0] stamp;
    logic stampRoll;
    logic [7:0] runTmr;
    logic [7:0] brkTmr;
    logic [7:0] levTmr;
    logic [7:0] doorTmr;
    logic [7:0] stuckTmr;
    logic [7:0] dupTmr;
    logic [7:0] dzTmr;
    logic [9:0] cleanTmr;
    logic [7:0] drvResets;
    logic [7:0] fsFails;
    logic levSeen;
    logic levLastUp;
    logic [1:0] levFlips;
    logic fsRun;
    logic floorSeen;
    logic [EFM_NF-1:0] condPrev;
    logic [EFM_NF-1:0] pend;
    efm_cfg_t cfg;
    logic coil;
    efm_act_t act;
    logic [EFM_LOG_N-1:0][15:0] log;
    logic [15:0] rdata;
  } efm_state_t;

endpackage
